// file: src/chain_params.svh
// Timing and width constants shared by both ends of the converter chain
`ifndef CHAIN_PARAMS_SVH
`define CHAIN_PARAMS_SVH

`define ADC_BITS 18
`define CLK_PERIOD_NS 50
`define CONV_TIME_NS 710
`define CONV_CYCLES ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_TIME_NS 100
`define SETUP_CYCLES ((`SETUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SCK_HALF_TIME_NS 200
`define SCK_HALF_CYCLES (`SCK_HALF_TIME_NS / `CLK_PERIOD_NS)
`define BUSY_TIMEOUT_CYCLES 255
`define FIFO_WIDTH 18
`define FIFO_DEPTH 32

`endif

// file: src/chain_pkg.sv
// State types of the converter end and the host end
`default_nettype none
package chain_pkg;
    typedef enum logic [1:0] {ADC_IDLE, ADC_CS, ADC_CONVERT, ADC_READ} adc_state_t;
    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_CONV, H_WAIT_BUSY, H_READ, H_END} host_state_t;
endpackage
`default_nettype wire

// file: src/chain_if.sv
// Four-wire chain link between host and converter, plus output enable
`timescale 1ns/10ps
`default_nettype none
interface chain_if;
    logic conversion_start;
    logic serial_clock;
    logic chain_serial_in;
    logic chain_serial_out;
    logic chain_serial_out_oe;
    modport adc (
        input conversion_start,
        input serial_clock,
        input chain_serial_in,
        output chain_serial_out,
        output chain_serial_out_oe
    );
    modport host (
        output conversion_start,
        output serial_clock,
        output chain_serial_in,
        input chain_serial_out,
        input chain_serial_out_oe
    );
endinterface
`default_nettype wire

// file: src/chain_adc_end.sv
// Converter end: chain-mode conversion and shift-register readout
`timescale 1ns/10ps
`default_nettype none
`include "chain_params.svh"
// How it works
// - Start-edge chain input low selects chain mode
// - Chain input and start low drive output low
// - Clock low at start edge: no busy bit
// - Clock high at start edge: busy bit enabled
// - Host keeps start high through conversion, readback
// - MSB appears at conversion end, then acquisition
// - Remaining bits shift out on clock falls
// - Chain input enters register on each fall but the busy-bit one
// - Host issues 18 times N clocks
// - Busy mode: output high when conversion done
// - Busy mode needs 18 times N plus one
// - Each bit stable across both clock edges
// - Host preferably captures on falling edge
module chain_adc_end (
    input wire logic clock,
    input wire logic resetn,
    chain_if.adc link,
    input wire logic [17:0] sample_data,
    output logic converting,
    output logic chain_mode,
    output logic busy_enabled,
    output logic [17:0] sampled_word
);
    // Link pins synchroniser: conversion_start, serial_clock, chain_serial_in
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic cnv_s;
    logic sck_s;
    logic sdi_s;
    logic cnv_d_r;
    logic cnv_d_nxt;
    logic sck_d_r;
    logic sck_d_nxt;
    logic cnv_rise;
    logic sck_fall;

    chain_pkg::adc_state_t state_r;
    chain_pkg::adc_state_t state_nxt;
    logic [4:0] conv_cnt_r;
    logic [4:0] conv_cnt_nxt;
    logic [17:0] sreg_r;
    logic [17:0] sreg_nxt;
    logic start_bit_r;
    logic start_bit_nxt;
    logic busy_en_r;
    logic busy_en_nxt;
    logic [17:0] sampled_r;
    logic [17:0] sampled_nxt;
    logic sdo_r;
    logic sdo_nxt;
    logic sdo_oe_r;
    logic sdo_oe_nxt;
    logic converting_r;
    logic converting_nxt;
    logic chain_mode_r;
    logic chain_mode_nxt;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
        end
        else
        begin
            sync1_r <= {link.conversion_start, link.serial_clock, link.chain_serial_in};
            sync2_r <= sync1_r;
        end
    end

    assign cnv_s = sync2_r[2];
    assign sck_s = sync2_r[1];
    assign sdi_s = sync2_r[0];
    assign cnv_rise = cnv_s && !cnv_d_r;
    assign sck_fall = !sck_s && sck_d_r;

    always_comb
    begin
        state_nxt = state_r;
        conv_cnt_nxt = conv_cnt_r;
        sreg_nxt = sreg_r;
        start_bit_nxt = start_bit_r;
        busy_en_nxt = busy_en_r;
        sampled_nxt = sampled_r;
        cnv_d_nxt = cnv_s;
        sck_d_nxt = sck_s;
        unique case (state_r)
            chain_pkg::ADC_IDLE:
            begin
                if (cnv_rise)
                begin
                    if (sdi_s)
                    begin
                        // Select-style modes are not served here
                        state_nxt = chain_pkg::ADC_CS;
                    end
                    else
                    begin
                        state_nxt = chain_pkg::ADC_CONVERT;
                        busy_en_nxt = sck_s;
                        conv_cnt_nxt = 5'(`CONV_CYCLES - 1);
                        sampled_nxt = sample_data;
                    end
                end
            end
            chain_pkg::ADC_CS:
            begin
                if (!cnv_s)
                begin
                    state_nxt = chain_pkg::ADC_IDLE;
                end
            end
            chain_pkg::ADC_CONVERT:
            begin
                if (!cnv_s)
                begin
                    // Start dropped mid-conversion: abandon the frame
                    state_nxt = chain_pkg::ADC_IDLE;
                end
                else if (conv_cnt_r == 5'h0)
                begin
                    state_nxt = chain_pkg::ADC_READ;
                    sreg_nxt = sampled_r;
                    start_bit_nxt = busy_en_r;
                end
                else
                begin
                    conv_cnt_nxt = conv_cnt_r - 5'h1;
                end
            end
            chain_pkg::ADC_READ:
            begin
                if (!cnv_s)
                begin
                    state_nxt = chain_pkg::ADC_IDLE;
                    start_bit_nxt = 1'b0;
                end
                else if (sck_fall)
                begin
                    if (start_bit_r)
                    begin
                        // First fall retires the busy bit; upstream busy bit is dropped
                        start_bit_nxt = 1'b0;
                    end
                    else
                    begin
                        sreg_nxt = {sreg_r[16:0], sdi_s};
                    end
                end
            end
        endcase
    end

    // Output pin: value and enable follow the next state so they settle in one clock
    always_comb
    begin
        sdo_nxt = 1'b0;
        sdo_oe_nxt = 1'b0;
        if (state_nxt == chain_pkg::ADC_READ)
        begin
            sdo_oe_nxt = 1'b1;
            sdo_nxt = start_bit_nxt ? 1'b1 : sreg_nxt[17];
        end
        else if (state_nxt == chain_pkg::ADC_CS)
        begin
            sdo_oe_nxt = 1'b0;
        end
        else if (!sdi_s && !cnv_s)
        begin
            sdo_oe_nxt = 1'b1;
        end
        else if (state_nxt == chain_pkg::ADC_CONVERT)
        begin
            // Held low until the result or busy bit is ready
            sdo_oe_nxt = 1'b1;
        end
    end

    always_comb
    begin
        converting_nxt = (state_nxt == chain_pkg::ADC_CONVERT);
        chain_mode_nxt = (state_nxt == chain_pkg::ADC_CONVERT) || (state_nxt == chain_pkg::ADC_READ);
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= chain_pkg::ADC_IDLE;
            conv_cnt_r <= 5'h0;
            sreg_r <= 18'h0_0000;
            start_bit_r <= 1'b0;
            busy_en_r <= 1'b0;
            sampled_r <= 18'h0_0000;
            cnv_d_r <= 1'b0;
            sck_d_r <= 1'b0;
            sdo_r <= 1'b0;
            sdo_oe_r <= 1'b0;
            converting_r <= 1'b0;
            chain_mode_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            conv_cnt_r <= conv_cnt_nxt;
            sreg_r <= sreg_nxt;
            start_bit_r <= start_bit_nxt;
            busy_en_r <= busy_en_nxt;
            sampled_r <= sampled_nxt;
            cnv_d_r <= cnv_d_nxt;
            sck_d_r <= sck_d_nxt;
            sdo_r <= sdo_nxt;
            sdo_oe_r <= sdo_oe_nxt;
            converting_r <= converting_nxt;
            chain_mode_r <= chain_mode_nxt;
        end
    end

    assign link.chain_serial_out = sdo_r;
    assign link.chain_serial_out_oe = sdo_oe_r;
    assign converting = converting_r;
    assign chain_mode = chain_mode_r;
    assign busy_enabled = busy_en_r;
    assign sampled_word = sampled_r;
endmodule
`default_nettype wire

// file: src/chain_host_end.sv
// Host end: frame sequencer, serial clock divider and word FIFO
`timescale 1ns/10ps
`default_nettype none
`include "chain_params.svh"

module chain_word_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 32
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] wr_ptr_nxt;
    logic [AW:0] rd_ptr_r;
    logic [AW:0] rd_ptr_nxt;
    logic [WIDTH-1:0] out_data_r;
    logic [WIDTH-1:0] out_data_nxt;
    logic out_valid_r;
    logic out_valid_nxt;
    logic empty;
    logic push;
    logic pop;

    assign empty = (wr_ptr_r == rd_ptr_r);
    assign in_ready = ((wr_ptr_r - rd_ptr_r) != (AW + 1)'(DEPTH));
    assign push = in_valid && in_ready;
    // Output stage reloads when empty or being drained
    assign pop = !empty && (!out_valid_r || out_ready);

    always_comb
    begin
        wr_ptr_nxt = push ? wr_ptr_r + (AW + 1)'(1) : wr_ptr_r;
        rd_ptr_nxt = pop ? rd_ptr_r + (AW + 1)'(1) : rd_ptr_r;
        out_data_nxt = pop ? mem[rd_ptr_r[AW-1:0]] : out_data_r;
        out_valid_nxt = pop ? 1'b1 : (out_valid_r && !out_ready);
    end

    always_ff @(posedge clock)
    begin
        if (push)
        begin
            mem[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            out_data_r <= '0;
            out_valid_r <= 1'b0;
        end
        else
        begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            out_data_r <= out_data_nxt;
            out_valid_r <= out_valid_nxt;
        end
    end

    assign out_data = out_data_r;
    assign out_valid = out_valid_r;
endmodule

module chain_host_end (
    input wire logic clock,
    input wire logic resetn,
    chain_if.host link,
    input wire logic start,
    input wire logic busy_mode,
    input wire logic [3:0] chain_len,
    output logic [17:0] word_data,
    output logic word_valid,
    input wire logic word_ready,
    output logic host_busy,
    output logic busy_timeout
);
    logic [1:0] sdo_sync1_r;
    logic [1:0] sdo_sync2_r;
    logic sdo_s;
    chain_pkg::host_state_t state_r;
    chain_pkg::host_state_t state_nxt;
    logic cnv_r;
    logic cnv_nxt;
    logic sck_r;
    logic sck_nxt;
    logic mode_r;
    logic mode_nxt;
    logic skip_r;
    logic skip_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [2:0] div_r;
    logic [2:0] div_nxt;
    logic [8:0] bits_left_r;
    logic [8:0] bits_left_nxt;
    logic [4:0] bitpos_r;
    logic [4:0] bitpos_nxt;
    logic [17:0] word_r;
    logic [17:0] word_nxt;
    logic push_r;
    logic push_nxt;
    logic host_busy_r;
    logic host_busy_nxt;
    logic timeout_r;
    logic timeout_nxt;
    logic fifo_in_ready;

    // Level and enable synchronised apart, so no gate sits ahead of the first flop
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            sdo_sync1_r <= 2'h0;
            sdo_sync2_r <= 2'h0;
        end
        else
        begin
            sdo_sync1_r <= {link.chain_serial_out, link.chain_serial_out_oe};
            sdo_sync2_r <= sdo_sync1_r;
        end
    end

    // Device pin read as wire level: undriven counts as low
    assign sdo_s = sdo_sync2_r[1] && sdo_sync2_r[0];

    always_comb
    begin
        state_nxt = state_r;
        cnv_nxt = cnv_r;
        sck_nxt = sck_r;
        mode_nxt = mode_r;
        skip_nxt = skip_r;
        cnt_nxt = cnt_r;
        div_nxt = div_r;
        bits_left_nxt = bits_left_r;
        bitpos_nxt = bitpos_r;
        word_nxt = word_r;
        push_nxt = push_r && !fifo_in_ready;
        timeout_nxt = timeout_r;
        unique case (state_r)
            chain_pkg::H_IDLE:
            begin
                cnv_nxt = 1'b0;
                sck_nxt = 1'b0;
                if (start && chain_len != 4'h0 && !push_r)
                begin
                    mode_nxt = busy_mode;
                    // Serial clock level before the start edge picks busy mode
                    sck_nxt = busy_mode;
                    cnt_nxt = 8'(`SETUP_CYCLES - 1);
                    bits_left_nxt = 9'(chain_len) * 9'(`ADC_BITS) + {8'h00, busy_mode};
                    timeout_nxt = 1'b0;
                    state_nxt = chain_pkg::H_SETUP;
                end
            end
            chain_pkg::H_SETUP:
            begin
                if (cnt_r == 8'h00)
                begin
                    cnv_nxt = 1'b1;
                    cnt_nxt = mode_r ? 8'(`BUSY_TIMEOUT_CYCLES) : 8'(`CONV_CYCLES + `SETUP_CYCLES);
                    state_nxt = mode_r ? chain_pkg::H_WAIT_BUSY : chain_pkg::H_CONV;
                end
                else
                begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            chain_pkg::H_CONV:
            begin
                if (cnt_r == 8'h00)
                begin
                    state_nxt = chain_pkg::H_READ;
                    div_nxt = 3'(`SCK_HALF_CYCLES - 1);
                    skip_nxt = 1'b0;
                    bitpos_nxt = 5'h00;
                end
                else
                begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            chain_pkg::H_WAIT_BUSY:
            begin
                if (sdo_s)
                begin
                    state_nxt = chain_pkg::H_READ;
                    div_nxt = 3'(`SCK_HALF_CYCLES - 1);
                    skip_nxt = 1'b1;
                    bitpos_nxt = 5'h00;
                end
                else if (cnt_r == 8'h00)
                begin
                    timeout_nxt = 1'b1;
                    state_nxt = chain_pkg::H_END;
                end
                else
                begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            chain_pkg::H_READ:
            begin
                if (div_r != 3'h0)
                begin
                    div_nxt = div_r - 3'h1;
                end
                else if (sck_r)
                begin
                    // Falling edge; held off while a finished word waits for room
                    if (!push_nxt)
                    begin
                        sck_nxt = 1'b0;
                        div_nxt = 3'(`SCK_HALF_CYCLES - 1);
                        bits_left_nxt = bits_left_r - 9'h001;
                        if (skip_r)
                        begin
                            skip_nxt = 1'b0;
                        end
                        else
                        begin
                            word_nxt = {word_r[16:0], sdo_s};
                            if (bitpos_r == 5'(`ADC_BITS - 1))
                            begin
                                bitpos_nxt = 5'h00;
                                push_nxt = 1'b1;
                            end
                            else
                            begin
                                bitpos_nxt = bitpos_r + 5'h01;
                            end
                        end
                    end
                end
                else if (bits_left_r == 9'h000)
                begin
                    state_nxt = chain_pkg::H_END;
                end
                else
                begin
                    sck_nxt = 1'b1;
                    div_nxt = 3'(`SCK_HALF_CYCLES - 1);
                end
            end
            chain_pkg::H_END:
            begin
                cnv_nxt = 1'b0;
                sck_nxt = 1'b0;
                state_nxt = chain_pkg::H_IDLE;
            end
            default:
            begin
                state_nxt = chain_pkg::H_IDLE;
            end
        endcase
        host_busy_nxt = (state_nxt != chain_pkg::H_IDLE);
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= chain_pkg::H_IDLE;
            cnv_r <= 1'b0;
            sck_r <= 1'b0;
            mode_r <= 1'b0;
            skip_r <= 1'b0;
            cnt_r <= 8'h00;
            div_r <= 3'h0;
            bits_left_r <= 9'h000;
            bitpos_r <= 5'h00;
            word_r <= 18'h0_0000;
            push_r <= 1'b0;
            host_busy_r <= 1'b0;
            timeout_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnv_r <= cnv_nxt;
            sck_r <= sck_nxt;
            mode_r <= mode_nxt;
            skip_r <= skip_nxt;
            cnt_r <= cnt_nxt;
            div_r <= div_nxt;
            bits_left_r <= bits_left_nxt;
            bitpos_r <= bitpos_nxt;
            word_r <= word_nxt;
            push_r <= push_nxt;
            host_busy_r <= host_busy_nxt;
            timeout_r <= timeout_nxt;
        end
    end

    chain_word_fifo #(
        .WIDTH(`FIFO_WIDTH),
        .DEPTH(`FIFO_DEPTH)
    ) word_fifo (
        .clock(clock),
        .resetn(resetn),
        .in_data(word_r),
        .in_valid(push_r),
        .in_ready(fifo_in_ready),
        .out_data(word_data),
        .out_valid(word_valid),
        .out_ready(word_ready)
    );

    assign link.conversion_start = cnv_r;
    assign link.serial_clock = sck_r;
    assign link.chain_serial_in = 1'b0;
    assign host_busy = host_busy_r;
    assign busy_timeout = timeout_r;
endmodule
`default_nettype wire

// file: sim/chain_link_monitor.sv
// Concurrent checks on the chain link between host and converter
`timescale 1ns/10ps
`default_nettype none
module chain_link_monitor #(
    parameter int CHAIN_N = 1
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic conversion_start,
    input wire logic serial_clock,
    input wire logic chain_serial_in,
    input wire logic chain_serial_out,
    input wire logic chain_serial_out_oe
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!resetn);

    logic [8:0] falls_r;
    logic [8:0] falls_nxt;
    logic busy_sel_r;
    logic busy_sel_nxt;
    logic sck_r;
    logic start_r;

    // Clock falls within a frame, and the busy choice made at its start
    always_comb
    begin
        falls_nxt = falls_r;
        busy_sel_nxt = busy_sel_r;
        if (!conversion_start)
            falls_nxt = 9'h000;
        else if (sck_r && !serial_clock)
            falls_nxt = falls_r + 9'h001;
        if (conversion_start && !start_r)
            busy_sel_nxt = serial_clock;
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            falls_r <= 9'h000;
            busy_sel_r <= 1'b0;
            sck_r <= 1'b0;
            start_r <= 1'b0;
        end
        else
        begin
            falls_r <= falls_nxt;
            busy_sel_r <= busy_sel_nxt;
            sck_r <= serial_clock;
            start_r <= conversion_start;
        end
    end

    sequence s_start_plain;
        $rose(conversion_start) && !serial_clock;
    endsequence
    sequence s_start_busy;
        $rose(conversion_start) && serial_clock;
    endsequence
    sequence s_busy_bit;
        chain_serial_out && chain_serial_out_oe;
    endsequence

    property p_idle_low;
        (!conversion_start && !chain_serial_in) [*6] |-> chain_serial_out_oe && !chain_serial_out;
    endproperty
    property p_plain_start;
        s_start_plain |-> (!serial_clock) [*8];
    endproperty
    property p_busy_start;
        s_start_busy |-> serial_clock throughout (##[1:40] s_busy_bit);
    endproperty
    property p_start_held;
        $rose(conversion_start) |=> conversion_start [*8];
    endproperty
    property p_driven_when_clocked;
        $rose(serial_clock) && conversion_start |-> chain_serial_out_oe;
    endproperty
    property p_fall_count;
        $fell(conversion_start) |-> int'(falls_r) == 18 * CHAIN_N + int'(busy_sel_r);
    endproperty
    property p_busy_bit;
        s_start_busy |-> ##[1:40] s_busy_bit;
    endproperty
    property p_bit_stable;
        $fell(serial_clock) |-> ##5 $stable(chain_serial_out) [*3];
    endproperty
    property p_far_in_low;
        !chain_serial_in;
    endproperty

    a_idle_low: assert property (p_idle_low)
        else $error("Output not driven low while idle");
    a_plain_start: assert property (p_plain_start)
        else $error("Clock left low phase too early");
    a_busy_start: assert property (p_busy_start)
        else $error("Clock dropped before busy bit");
    a_start_held: assert property (p_start_held)
        else $error("Start line dropped during conversion");
    a_driven_when_clocked: assert property (p_driven_when_clocked)
        else $error("Output undriven while clocked");
    a_fall_count: assert property (p_fall_count)
        else $error("Wrong number of clock falls in frame");
    a_busy_bit: assert property (p_busy_bit)
        else $error("Busy bit missing after conversion");
    a_bit_stable: assert property (p_bit_stable)
        else $error("Output bit changed across clock edge");
    a_far_in_low: assert property (p_far_in_low)
        else $error("Far chain input not low");
endmodule
`default_nettype wire

// file: sim/tb_adc_daisy_chain_readout.sv
// Bench for host end and one converter joined by the chain link
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end
module tb_adc_daisy_chain_readout;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic start = 1'b0;
    logic busy_mode = 1'b0;
    logic [3:0] chain_len = 4'h1;
    logic word_ready = 1'b0;
    logic [17:0] sample_data = 18'h0_0000;
    logic [17:0] word_data;
    logic [17:0] sampled_word;
    logic word_valid, host_busy, busy_timeout, converting, chain_mode, busy_enabled;
    int bad_count = 0;
    int n_tests = 0;
    int cycles = 0;

    always #25 clock = ~clock;

    chain_if chain_if_inst ();
    chain_adc_end chain_adc_end_inst (.clock(clock), .resetn(resetn), .link(chain_if_inst),
        .sample_data(sample_data), .converting(converting), .chain_mode(chain_mode),
        .busy_enabled(busy_enabled), .sampled_word(sampled_word));
    chain_host_end chain_host_end_inst (.clock(clock), .resetn(resetn), .link(chain_if_inst),
        .start(start), .busy_mode(busy_mode), .chain_len(chain_len), .word_data(word_data),
        .word_valid(word_valid), .word_ready(word_ready), .host_busy(host_busy),
        .busy_timeout(busy_timeout));
    chain_link_monitor #(.CHAIN_N(1)) chain_link_monitor_inst (.clock(clock), .resetn(resetn),
        .conversion_start(chain_if_inst.conversion_start), .serial_clock(chain_if_inst.serial_clock),
        .chain_serial_in(chain_if_inst.chain_serial_in), .chain_serial_out(chain_if_inst.chain_serial_out),
        .chain_serial_out_oe(chain_if_inst.chain_serial_out_oe));

    task automatic final_report;
        if (bad_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic frame(input logic bm, input logic [17:0] d);
        @(posedge clock);
        sample_data <= d;
        busy_mode <= bm;
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        @(negedge clock);
    endtask

    task automatic wait_idle;
        repeat (2000) if (host_busy === 1'b1) @(negedge clock);
        `CHK(host_busy, 1'b0)
    endtask

    task automatic pop(input logic [17:0] exp);
        @(posedge clock);
        word_ready <= 1'b1;
        @(negedge clock);
        repeat (50) if (word_valid !== 1'b1) @(negedge clock);
        `CHK({word_valid, word_data}, {1'b1, exp})
        @(posedge clock);
        word_ready <= 1'b0;
    endtask

    task automatic one_frame(input logic bm, input logic [17:0] d);
        frame(bm, d);
        repeat (10) @(negedge clock);
        `CHK({converting, chain_mode}, 2'b11)
        wait_idle();
        `CHK(busy_enabled, bm)
        `CHK(busy_timeout, 1'b0)
        `CHK(sampled_word, d)
        pop(d);
    endtask

    // Readout without busy bit, boundary words, then idle line level
    task automatic t_plain;
        logic [17:0] vals [3] = '{18'h2_D3C5, 18'h3_FFFF, 18'h0_0001};
        foreach (vals[i])
            one_frame(1'b0, vals[i]);
        repeat (6) @(negedge clock);
        `CHK({chain_if_inst.chain_serial_out_oe, chain_if_inst.chain_serial_out}, 2'b10)
    endtask

    task automatic t_busy;
        logic [17:0] vals [3] = '{18'h1_2A5B, 18'h2_0000, 18'h3_FFFE};
        foreach (vals[i])
            one_frame(1'b1, vals[i]);
        `CHK(converting, 1'b0)
    endtask

    // Fill the word buffer, leave one finished frame's word waiting for room, then drain in order
    task automatic t_fill;
        for (int i = 0; i < 33; i++)
        begin
            frame(i[0], {i[5:0], 12'ha5c});
            wait_idle();
        end
        `CHK(word_valid, 1'b1)
        frame(1'b1, 18'h2_4924);
        repeat (400) @(negedge clock);
        `CHK(host_busy, 1'b0)
        for (int i = 0; i < 33; i++)
            pop({i[5:0], 12'ha5c});
        wait_idle();
        pop(18'h2_4924);
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            bad_count++;
            final_report();
        end
    end

    initial
    begin
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        t_plain();
        t_busy();
        t_fill();
        final_report();
    end
endmodule
`default_nettype wire
